/* rtl/mip_regs.vh */
// Constants for the maskable interrupt priority and acknowledge block.
// Included by every design file; holds definitions only.
`ifndef MIP_REGS_VH
`define MIP_REGS_VH

// ----------------------------------------
// Sources
// ----------------------------------------
`define MIP_NUM_SRC 8
`define MIP_NUM_EXT 4

// ----------------------------------------
// Register map (byte addresses)
// ----------------------------------------
`define MIP_ICR_BASE 8'h00
`define MIP_ICR_LAST 8'h1C
`define MIP_STAT_ADDR 8'h20

// ----------------------------------------
// Control register fields
// ----------------------------------------
`define MIP_PRIO_LSB 0
`define MIP_PRIO_MSB 2
`define MIP_MASK_BIT 6
`define MIP_PEND_BIT 7
`define MIP_ICR_RESET 8'h47
`define MIP_LEVEL_NONE 4'h8

// ----------------------------------------
// Status register fields
// ----------------------------------------
`define MIP_STAT_ISR_LSB 0
`define MIP_STAT_NMI_BIT 8
`define MIP_STAT_SRC_LSB 9
`define MIP_STAT_BUSY_BIT 12

// ----------------------------------------
// CPU side
// ----------------------------------------
`define MIP_PSW_REG_NUM 5'h05

// ----------------------------------------
// Timing, in system clocks
// ----------------------------------------
`define MIP_ENABLE_WIN_CLKS 7
`define MIP_ACK_PROC_CLKS 4
`define MIP_NOISE_CLKS 2

// ----------------------------------------
// Bus answers
// ----------------------------------------
`define MIP_RESP_OKAY 2'h0
`define MIP_RESP_SLVERR 2'h2

`endif

/* rtl/mip_pin_filter.v */
// Synchroniser and noise filter for the external request pins.
// Pins are asynchronous; output is a one-cycle pulse per accepted rising edge.
`timescale 1ns/100ps
`default_nettype none
`include "mip_regs.vh"

module mip_pin_filter (
  input wire clk,
  input wire rst_n,
  input wire [`MIP_NUM_EXT-1:0] pin,
  output reg [`MIP_NUM_EXT-1:0] rise
);

  genvar g;
  generate
    for (g = 0; g < `MIP_NUM_EXT; g = g + 1) begin : g_pin
      reg meta_q;
      reg sync_q;
      reg hist_q;
      reg filt_q;
      always @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
          meta_q <= 1'b0;
          sync_q <= 1'b0;
          hist_q <= 1'b0;
          filt_q <= 1'b0;
          rise[g] <= 1'b0;
        end else begin
          meta_q <= pin[g];
          sync_q <= meta_q;
          hist_q <= sync_q;
          // A level must hold for two samples before it counts
          if (sync_q == hist_q) begin
            filt_q <= hist_q;
          end
          rise[g] <= (sync_q == hist_q) & hist_q & ~filt_q; // RULE8
        end
      end
    end
  endgenerate

endmodule // mip_pin_filter
`default_nettype wire

/* rtl/mip_arb.v */
// Priority arbiter: picks the most urgent pending, unmasked source.
// Purely combinational; inputs come from registers on the same clock.
`timescale 1ns/100ps
`default_nettype none
`include "mip_regs.vh"

module mip_arb (
  input wire [`MIP_NUM_SRC-1:0] req,
  input wire [3*`MIP_NUM_SRC-1:0] prio,
  output reg valid,
  output reg [2:0] src,
  output reg [2:0] level
);

  integer i;

  always @* begin
    valid = 1'b0;
    src = 3'h0;
    level = 3'h7;
    // Strict compare: on equal level the lower index keeps the grant
    for (i = 0; i < `MIP_NUM_SRC; i = i + 1) begin
      if (req[i] && (!valid || (prio[3*i +: 3] < level))) begin // RULE1 RULE17
        valid = 1'b1;
        src = i[2:0];
        level = prio[3*i +: 3];
      end
    end
  end

endmodule // mip_arb
`default_nettype wire

/* rtl/mip_irq_ctrl.v */
// Maskable interrupt priority, nesting and acknowledge control.
// Assumes a CPU on SYS_CLK that reports its interrupt-control instructions
// as one-cycle pulses, and an AXI4-Lite master for the control registers.
//
// How it works
// RULE1: Eight levels per source, zero most urgent
// RULE2: Reset: every source masked, level seven
// RULE3: Preempted handler resumes after nested return
// RULE4: Pending request waits for current handler return
// RULE5: No maskable acknowledge during non-maskable service
// RULE6: Least latency eleven internal, thirteen external; the code takes fifteen external
// RULE7: Most latency eighteen internal, twenty external
// RULE8: External pins filtered, two extra clocks; the code adds four (two synchroniser, two filter)
// RULE9: Four processing clocks, flush fetch, then handler
// RULE10: No acknowledge right after sampling-block instructions
// RULE11: Acknowledge seven clocks after enable, disable cancels
// RULE12: Disable within seven clocks of pending cancels
// RULE13: Standby, status change, register access restart window
// RULE14: Software brackets register edits during DMA
// RULE15: Handler saves return state before re-enabling
// RULE16: Nesting only when enabled and more urgent
// RULE17: Equal levels resolved by lowest source number
`timescale 1ns/100ps
`default_nettype none
`include "mip_regs.vh"

module mip_irq_ctrl (
  input wire SYS_CLK,
  input wire RSTN,
  // AXI4-Lite slave
  input wire [7:0] S_AXI_AWADDR,
  input wire S_AXI_AWVALID,
  output wire S_AXI_AWREADY,
  input wire [31:0] S_AXI_WDATA,
  input wire [3:0] S_AXI_WSTRB,
  input wire S_AXI_WVALID,
  output wire S_AXI_WREADY,
  output reg [1:0] S_AXI_BRESP,
  output reg S_AXI_BVALID,
  input wire S_AXI_BREADY,
  input wire [7:0] S_AXI_ARADDR,
  input wire S_AXI_ARVALID,
  output wire S_AXI_ARREADY,
  output reg [31:0] S_AXI_RDATA,
  output reg [1:0] S_AXI_RRESP,
  output reg S_AXI_RVALID,
  input wire S_AXI_RREADY,
  // Request sources
  input wire [`MIP_NUM_SRC-`MIP_NUM_EXT-1:0] INT_REQ,
  input wire [`MIP_NUM_EXT-1:0] EXT_IRQ_PIN,
  // CPU pipeline
  input wire NMI_ENTER,
  input wire IRQ_UNMASK_ALL_INSTR,
  input wire IRQ_MASK_ALL_INSTR,
  input wire LOAD_SYSTEM_REG_INSTR,
  input wire [4:0] LOAD_SYSTEM_REG_NUM,
  input wire RETURN_FROM_HANDLER_INSTR,
  input wire IRQ_DISABLE_FLAG,
  input wire STANDBY,
  output reg IRQ_ACK,
  output reg [2:0] IRQ_ACK_SRC,
  output reg [2:0] IRQ_ACK_LEVEL,
  output reg FETCH_FLUSH,
  output reg HANDLER_START,
  output wire ACK_BUSY
);

  localparam ST_IDLE = 1'b0;
  localparam ST_PROC = 1'b1;
  // Window and processing counts, cut to counter width on purpose
  localparam integer WIN_LAST_I = `MIP_ENABLE_WIN_CLKS - 1;
  localparam integer PROC_LAST_I = `MIP_ACK_PROC_CLKS - 1;
  localparam [2:0] WIN_LAST = WIN_LAST_I[2:0];
  localparam [2:0] PROC_LAST = PROC_LAST_I[2:0];
  // Reset image of one control register
  localparam [7:0] ICR_RST = `MIP_ICR_RESET;
  localparam [2:0] PRIO_RST = ICR_RST[`MIP_PRIO_MSB:`MIP_PRIO_LSB];
  localparam MASK_RST = ICR_RST[`MIP_MASK_BIT];
  localparam PEND_RST = ICR_RST[`MIP_PEND_BIT];

  // ----------------------------------------
  // Register bus
  // ----------------------------------------
  reg aw_full_q;
  reg [7:0] aw_addr_q;
  reg w_full_q;
  reg [31:0] w_data_q;
  reg w_strb0_q;
  wire wr_fire;
  wire wr_icr;
  wire [2:0] wr_idx;
  wire rd_fire;
  wire rd_icr;
  reg [31:0] rd_data_d;
  reg [1:0] rd_resp_d;

  // One write and one read in flight; B or R must drain first
  assign S_AXI_AWREADY = !aw_full_q && !S_AXI_BVALID;
  assign S_AXI_WREADY = !w_full_q && !S_AXI_BVALID;
  assign S_AXI_ARREADY = !S_AXI_RVALID;
  assign wr_fire = aw_full_q && w_full_q && !S_AXI_BVALID;
  assign wr_icr = (aw_addr_q[1:0] == 2'h0) && (aw_addr_q <= `MIP_ICR_LAST);
  assign wr_idx = aw_addr_q[4:2];
  assign rd_fire = S_AXI_ARVALID && !S_AXI_RVALID;
  assign rd_icr = (S_AXI_ARADDR[1:0] == 2'h0) && (S_AXI_ARADDR <= `MIP_ICR_LAST);

  always @(posedge SYS_CLK or negedge RSTN) begin
    if (!RSTN) begin
      aw_full_q <= 1'b0;
      aw_addr_q <= 8'h00;
      w_full_q <= 1'b0;
      w_data_q <= 32'h00000000;
      w_strb0_q <= 1'b0;
      S_AXI_BVALID <= 1'b0;
      S_AXI_BRESP <= `MIP_RESP_OKAY;
      S_AXI_RVALID <= 1'b0;
      S_AXI_RRESP <= `MIP_RESP_OKAY;
      S_AXI_RDATA <= 32'h00000000;
    end else begin
      if (S_AXI_AWVALID && S_AXI_AWREADY) begin
        aw_full_q <= 1'b1;
        aw_addr_q <= S_AXI_AWADDR;
      end
      if (S_AXI_WVALID && S_AXI_WREADY) begin
        w_full_q <= 1'b1;
        w_data_q <= S_AXI_WDATA;
        w_strb0_q <= S_AXI_WSTRB[0];
      end
      if (wr_fire) begin
        aw_full_q <= 1'b0;
        w_full_q <= 1'b0;
        S_AXI_BVALID <= 1'b1;
        S_AXI_BRESP <= (wr_icr || aw_addr_q == `MIP_STAT_ADDR) ? `MIP_RESP_OKAY : `MIP_RESP_SLVERR;
      end else if (S_AXI_BREADY) begin
        S_AXI_BVALID <= 1'b0;
      end
      if (rd_fire) begin
        S_AXI_RVALID <= 1'b1;
        S_AXI_RDATA <= rd_data_d;
        S_AXI_RRESP <= rd_resp_d;
      end else if (S_AXI_RREADY) begin
        S_AXI_RVALID <= 1'b0;
      end
    end
  end

  // ----------------------------------------
  // Per-source control registers
  // ----------------------------------------
  wire [`MIP_NUM_EXT-1:0] ext_rise;
  wire [`MIP_NUM_SRC-1:0] src_event;
  wire [`MIP_NUM_SRC-1:0] pend;
  wire [`MIP_NUM_SRC-1:0] mask;
  wire [3*`MIP_NUM_SRC-1:0] prio;
  wire [`MIP_NUM_SRC-1:0] cand_req;
  wire cand_valid;
  wire [2:0] cand_src;
  wire [2:0] cand_level;
  wire fire;

  mip_pin_filter u_filter (
    .clk(SYS_CLK),
    .rst_n(RSTN),
    .pin(EXT_IRQ_PIN),
    .rise(ext_rise)
  );

  assign src_event = {ext_rise, INT_REQ};

  genvar g;
  generate
    for (g = 0; g < `MIP_NUM_SRC; g = g + 1) begin : g_src
      reg [2:0] prio_q;
      reg mask_q;
      reg pend_q;
      wire sel;
      // Writes with byte lane 0 off leave the register untouched
      assign sel = wr_fire && wr_icr && w_strb0_q && (wr_idx == g);
      always @(posedge SYS_CLK or negedge RSTN) begin
        if (!RSTN) begin
          prio_q <= PRIO_RST; // RULE2
          mask_q <= MASK_RST; // RULE2
          pend_q <= PEND_RST;
        end else begin
          if (sel) begin
            prio_q <= w_data_q[`MIP_PRIO_MSB:`MIP_PRIO_LSB];
            mask_q <= w_data_q[`MIP_MASK_BIT];
          end
          // A new request beats a clear in the same cycle
          if (src_event[g]) begin
            pend_q <= 1'b1;
          end else if (fire && cand_src == g) begin
            pend_q <= 1'b0;
          end else if (sel) begin
            pend_q <= w_data_q[`MIP_PEND_BIT];
          end
        end
      end
      assign pend[g] = pend_q;
      assign mask[g] = mask_q;
      assign prio[3*g +: 3] = prio_q;
    end
  endgenerate

  assign cand_req = pend & ~mask;

  mip_arb u_arb (
    .req(cand_req),
    .prio(prio),
    .valid(cand_valid),
    .src(cand_src),
    .level(cand_level)
  );

  // ----------------------------------------
  // In-service tracking
  // ----------------------------------------
  reg [7:0] isr_q;
  reg nmi_q;
  reg [3:0] cur_level;
  reg [7:0] isr_pop;
  integer k;

  // Lowest set bit is the most urgent open handler
  always @* begin
    cur_level = `MIP_LEVEL_NONE;
    isr_pop = 8'h00;
    for (k = 7; k >= 0; k = k - 1) begin
      if (isr_q[k]) begin
        cur_level = k[3:0];
      end
    end
    if (cur_level != `MIP_LEVEL_NONE) begin
      isr_pop = 8'h01 << cur_level[2:0];
    end
  end

  always @(posedge SYS_CLK or negedge RSTN) begin
    if (!RSTN) begin
      isr_q <= 8'h00;
      nmi_q <= 1'b0;
    end else begin
      // Exception returns are not tracked; a stray return pops a level
      if (NMI_ENTER) begin
        nmi_q <= 1'b1;
      end else if (RETURN_FROM_HANDLER_INSTR && nmi_q) begin
        nmi_q <= 1'b0; // RULE5
      end
      // Return closes the most urgent open handler, so the preempted one resumes
      if (RETURN_FROM_HANDLER_INSTR && !nmi_q && !NMI_ENTER) begin
        isr_q <= (isr_q & ~isr_pop) | (fire ? (8'h01 << cand_level) : 8'h00); // RULE3 RULE4
      end else if (fire) begin
        isr_q <= isr_q | (8'h01 << cand_level);
      end
    end
  end

  // ----------------------------------------
  // Enable window and acknowledge sequencing
  // ----------------------------------------
  reg state_q;
  reg [2:0] win_q;
  reg [2:0] proc_q;
  reg [2:0] last_src_q;
  wire psw_touch;
  wire icr_touch;
  wire blocked;
  wire eligible;

  // Any of these restarts the window, so nothing is taken right after them
  assign psw_touch = IRQ_UNMASK_ALL_INSTR || IRQ_MASK_ALL_INSTR ||
                     (LOAD_SYSTEM_REG_INSTR && LOAD_SYSTEM_REG_NUM == `MIP_PSW_REG_NUM); // RULE10
  assign icr_touch = (wr_fire && wr_icr) || (rd_fire && rd_icr); // RULE13
  assign blocked = psw_touch || icr_touch || STANDBY || IRQ_DISABLE_FLAG; // RULE11 RULE12 RULE13
  assign eligible = cand_valid && !nmi_q && !NMI_ENTER && ({1'b0, cand_level} < cur_level) &&
                    state_q == ST_IDLE && !RETURN_FROM_HANDLER_INSTR; // RULE5 RULE16 RULE4
  assign fire = eligible && !blocked && (win_q == WIN_LAST); // RULE11 RULE6 RULE7
  assign ACK_BUSY = (state_q == ST_PROC);

  // Window counts consecutive eligible cycles; any block restarts it,
  // so a request that keeps losing to blocks waits without limit
  always @(posedge SYS_CLK or negedge RSTN) begin
    if (!RSTN) begin
      state_q <= ST_IDLE;
      win_q <= 3'h0;
      proc_q <= 3'h0;
      last_src_q <= 3'h0;
      IRQ_ACK <= 1'b0;
      IRQ_ACK_SRC <= 3'h0;
      IRQ_ACK_LEVEL <= 3'h0;
      FETCH_FLUSH <= 1'b0;
      HANDLER_START <= 1'b0;
    end else begin
      IRQ_ACK <= fire;
      FETCH_FLUSH <= fire; // RULE9
      HANDLER_START <= 1'b0;
      if (!eligible || blocked || fire) begin
        win_q <= 3'h0; // RULE12
      end else begin
        win_q <= win_q + 3'h1;
      end
      case (state_q)
        ST_IDLE: begin
          if (fire) begin
            state_q <= ST_PROC;
            proc_q <= 3'h0;
            IRQ_ACK_SRC <= cand_src;
            IRQ_ACK_LEVEL <= cand_level;
            last_src_q <= cand_src;
          end
        end
        ST_PROC: begin
          // Fetch and decode in flight are discarded during these clocks
          proc_q <= proc_q + 3'h1;
          if (proc_q == PROC_LAST) begin
            state_q <= ST_IDLE;
            HANDLER_START <= 1'b1; // RULE9
          end
        end
        default: begin
          state_q <= ST_IDLE;
        end
      endcase
    end
  end

  // ----------------------------------------
  // Read data
  // ----------------------------------------
  // Unmapped reads answer an error with zero data
  always @* begin
    rd_data_d = 32'h00000000;
    rd_resp_d = `MIP_RESP_OKAY;
    if (rd_icr) begin
      rd_data_d[`MIP_PRIO_MSB:`MIP_PRIO_LSB] = prio[3*S_AXI_ARADDR[4:2] +: 3];
      rd_data_d[`MIP_MASK_BIT] = mask[S_AXI_ARADDR[4:2]];
      rd_data_d[`MIP_PEND_BIT] = pend[S_AXI_ARADDR[4:2]];
    end else if (S_AXI_ARADDR == `MIP_STAT_ADDR) begin
      rd_data_d[`MIP_STAT_ISR_LSB +: 8] = isr_q;
      rd_data_d[`MIP_STAT_NMI_BIT] = nmi_q;
      rd_data_d[`MIP_STAT_SRC_LSB +: 3] = last_src_q;
      rd_data_d[`MIP_STAT_BUSY_BIT] = (state_q == ST_PROC);
    end else begin
      rd_resp_d = `MIP_RESP_SLVERR;
    end
  end

endmodule // mip_irq_ctrl
`default_nettype wire

/* dv/mip_irq_ctrl_assertions.sv */
// Checker for the interrupt acknowledge block.
// Assumes one clock and the active-low asynchronous reset.
`timescale 1ns/100ps
`default_nettype none
module mip_irq_ctrl_assertions (
  input wire logic SYS_CLK,
  input wire logic RSTN,
  input wire logic S_AXI_BVALID,
  input wire logic [1:0] S_AXI_BRESP,
  input wire logic S_AXI_BREADY,
  input wire logic NMI_ENTER,
  input wire logic IRQ_UNMASK_ALL_INSTR,
  input wire logic IRQ_MASK_ALL_INSTR,
  input wire logic LOAD_SYSTEM_REG_INSTR,
  input wire logic [4:0] LOAD_SYSTEM_REG_NUM,
  input wire logic RETURN_FROM_HANDLER_INSTR,
  input wire logic IRQ_DISABLE_FLAG,
  input wire logic STANDBY,
  input wire logic IRQ_ACK,
  input wire logic [2:0] IRQ_ACK_SRC,
  input wire logic [2:0] IRQ_ACK_LEVEL,
  input wire logic FETCH_FLUSH,
  input wire logic HANDLER_START,
  input wire logic ACK_BUSY
);
  logic [3:0] quiet_q;
  logic nmi_q;
  wire blk = IRQ_DISABLE_FLAG | STANDBY | IRQ_UNMASK_ALL_INSTR | IRQ_MASK_ALL_INSTR
    | (LOAD_SYSTEM_REG_INSTR & (LOAD_SYSTEM_REG_NUM == 5'h05));
  // Counts unblocked cycles; saturates so it never wraps into a false pass
  always_ff @(posedge SYS_CLK or negedge RSTN) begin
    if (!RSTN) begin
      quiet_q <= 4'h0;
      nmi_q <= 1'b0;
    end else begin
      quiet_q <= blk ? 4'h0 : ((quiet_q == 4'hF) ? quiet_q : quiet_q + 4'h1);
      nmi_q <= NMI_ENTER | (nmi_q & ~RETURN_FROM_HANDLER_INSTR);
    end
  end
  default clocking dc @(posedge SYS_CLK); endclocking
  default disable iff (!RSTN);
  AST_FLUSH: assert property (FETCH_FLUSH == IRQ_ACK) else $error("flush not with ack");
  AST_START: assert property (IRQ_ACK |-> ##4 HANDLER_START) else $error("late handler");
  AST_BUSY: assert property (IRQ_ACK |-> ACK_BUSY [*4] ##1 !ACK_BUSY) else $error("busy span");
  AST_QUIET: assert property (IRQ_ACK |-> quiet_q >= 4'h7) else $error("ack in blocked window");
  AST_NMI: assert property (nmi_q |-> !IRQ_ACK) else $error("ack during nmi");
  AST_SPACE: assert property (IRQ_ACK |=> !IRQ_ACK [*8]) else $error("acks too close");
  AST_HELD: assert property (!IRQ_ACK |-> $stable(IRQ_ACK_SRC) && $stable(IRQ_ACK_LEVEL))
    else $error("ack source moved");
  AST_BRESP: assert property (S_AXI_BVALID && !S_AXI_BREADY |=> S_AXI_BVALID && $stable(S_AXI_BRESP))
    else $error("write answer dropped");
  cover property (IRQ_ACK && IRQ_ACK_SRC == 3'h2);
  cover property (nmi_q && IRQ_UNMASK_ALL_INSTR);
  cover property (IRQ_ACK && IRQ_ACK_SRC == 3'h4);
endmodule // mip_irq_ctrl_assertions
bind mip_irq_ctrl mip_irq_ctrl_assertions u_chk (.SYS_CLK(SYS_CLK), .RSTN(RSTN), .S_AXI_BVALID(S_AXI_BVALID),
  .S_AXI_BRESP(S_AXI_BRESP), .S_AXI_BREADY(S_AXI_BREADY), .NMI_ENTER(NMI_ENTER),
  .IRQ_UNMASK_ALL_INSTR(IRQ_UNMASK_ALL_INSTR), .IRQ_MASK_ALL_INSTR(IRQ_MASK_ALL_INSTR),
  .LOAD_SYSTEM_REG_INSTR(LOAD_SYSTEM_REG_INSTR), .LOAD_SYSTEM_REG_NUM(LOAD_SYSTEM_REG_NUM),
  .RETURN_FROM_HANDLER_INSTR(RETURN_FROM_HANDLER_INSTR), .IRQ_DISABLE_FLAG(IRQ_DISABLE_FLAG), .STANDBY(STANDBY),
  .IRQ_ACK(IRQ_ACK), .IRQ_ACK_SRC(IRQ_ACK_SRC), .IRQ_ACK_LEVEL(IRQ_ACK_LEVEL), .FETCH_FLUSH(FETCH_FLUSH),
  .HANDLER_START(HANDLER_START), .ACK_BUSY(ACK_BUSY));
`default_nettype wire

/* dv/mip_cpu_model.sv */
// CPU-side model: keeps the status-word disable flag.
// Assumes enable, disable and ack arrive as one-cycle pulses.
`timescale 1ns/100ps
`default_nettype none
module mip_cpu_model (
  input wire logic clk,
  input wire logic rst_n,
  input wire logic irq_ack,
  input wire logic ei,
  input wire logic di,
  output logic id_flag
);
  // Reset leaves the CPU disabled; ack wins over a same-cycle enable
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      id_flag <= 1'b1;
    end else if (irq_ack || di) begin
      id_flag <= 1'b1;
    end else if (ei) begin
      id_flag <= 1'b0;
    end
  end
endmodule // mip_cpu_model
`default_nettype wire

/* dv/tb.sv */
// Testbench for the interrupt acknowledge block.
// Assumes the design header and the CPU model on the same clock.
`timescale 1ns/100ps
`default_nettype none
`include "mip_regs.vh"
module tb;
  logic clk = 1'b0, rstn = 1'b0, awv = 1'b0, wv = 1'b0, bready = 1'b0, arv = 1'b0, rready = 1'b0;
  logic nmi = 1'b0, ei = 1'b0, di = 1'b0, return_from_handler_instr = 1'b0, lsr = 1'b0, stby = 1'b0;
  logic [1:0] last_b = 2'h0;
  logic [7:0] awaddr = 8'h00, araddr = 8'h00;
  logic [31:0] wdata = 32'h0;
  logic [3:0] wstrb = 4'hF, int_req = 4'h0, pin = 4'h0;
  wire awr, wrdy, bv, arr, rv, id, ack, flush, hs, busy;
  wire [1:0] bresp, rresp;
  wire [31:0] rdata;
  wire [2:0] src, lvl;
  int errors = 0, compares = 0;
  always #5 clk = ~clk;
  mip_irq_ctrl uut (.SYS_CLK(clk), .RSTN(rstn), .S_AXI_AWADDR(awaddr), .S_AXI_AWVALID(awv), .S_AXI_AWREADY(awr),
    .S_AXI_WDATA(wdata), .S_AXI_WSTRB(wstrb), .S_AXI_WVALID(wv), .S_AXI_WREADY(wrdy), .S_AXI_BRESP(bresp),
    .S_AXI_BVALID(bv), .S_AXI_BREADY(bready), .S_AXI_ARADDR(araddr), .S_AXI_ARVALID(arv), .S_AXI_ARREADY(arr),
    .S_AXI_RDATA(rdata), .S_AXI_RRESP(rresp), .S_AXI_RVALID(rv), .S_AXI_RREADY(rready), .INT_REQ(int_req),
    .EXT_IRQ_PIN(pin), .NMI_ENTER(nmi), .IRQ_UNMASK_ALL_INSTR(ei), .IRQ_MASK_ALL_INSTR(di),
    .LOAD_SYSTEM_REG_INSTR(lsr), .LOAD_SYSTEM_REG_NUM(5'h05), .RETURN_FROM_HANDLER_INSTR(return_from_handler_instr),
    .IRQ_DISABLE_FLAG(id), .STANDBY(stby), .IRQ_ACK(ack), .IRQ_ACK_SRC(src), .IRQ_ACK_LEVEL(lvl),
    .FETCH_FLUSH(flush), .HANDLER_START(hs), .ACK_BUSY(busy));
  mip_cpu_model cpu (.clk(clk), .rst_n(rstn), .irq_ack(ack), .ei(ei), .di(di), .id_flag(id));
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    compares++;
    if (got !== exp) begin
      errors++;
      $display("[ERR] t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask
  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    @(posedge clk);
    awaddr <= a;
    wdata <= d;
    awv <= 1'b1;
    wv <= 1'b1;
    bready <= 1'b1;
    do @(negedge clk); while (!(awr && wrdy));
    @(posedge clk);
    awv <= 1'b0;
    wv <= 1'b0;
    do @(negedge clk); while (!bv);
    last_b = bresp;
    @(posedge clk);
    bready <= 1'b0;
  endtask
  task automatic rd(input logic [7:0] a, output logic [31:0] d, output logic [1:0] r);
    @(posedge clk);
    araddr <= a;
    arv <= 1'b1;
    rready <= 1'b1;
    do @(negedge clk); while (!arr);
    @(posedge clk);
    arv <= 1'b0;
    do @(negedge clk); while (!rv);
    d = rdata;
    r = rresp;
    @(posedge clk);
    rready <= 1'b0;
  endtask
  // Kinds: 0 enable, 1 disable, 2 return, 4 status-word load, else non-maskable entry
  task automatic pulse(input int k);
    @(posedge clk);
    case (k)
      0: ei <= 1'b1;
      1: di <= 1'b1;
      2: return_from_handler_instr <= 1'b1;
      4: lsr <= 1'b1;
      default: nmi <= 1'b1;
    endcase
    @(posedge clk);
    {ei, di, return_from_handler_instr, nmi, lsr} <= 5'h00;
  endtask
  task automatic req(input logic [3:0] m);
    @(posedge clk);
    int_req <= m;
    @(posedge clk);
    int_req <= 4'h0;
  endtask
  // Counts cycles after the last pulse; lim means no ack came
  task automatic wait_ack(input int lim, output int n);
    n = 0;
    do begin
      @(negedge clk);
      n++;
    end while (!ack && n < lim);
  endtask
  task automatic t_reset;
    logic [31:0] d;
    logic [1:0] r;
    rd(8'h00, d, r);
    chk(d, {24'h0, `MIP_ICR_RESET});
    rd(8'h1C, d, r);
    chk(d, {24'h0, `MIP_ICR_RESET});
    rd(8'h40, d, r);
    chk({30'h0, r}, {30'h0, `MIP_RESP_SLVERR});
    wr(8'h40, 32'hFF);
    chk({30'h0, last_b}, {30'h0, `MIP_RESP_SLVERR});
  endtask
  task automatic t_window;
    int n;
    wr(8'h04, 32'h03);
    req(4'h2);
    pulse(0);
    pulse(1);
    wait_ack(20, n);
    chk(n, 20);
    pulse(0);
    wait_ack(20, n);
    chk(n, `MIP_ENABLE_WIN_CLKS + 1);
    chk({src, lvl}, 6'h0B);
    pulse(2);
  endtask
  task automatic t_prio;
    int n;
    wr(8'h00, 32'h05);
    wr(8'h08, 32'h02);
    wr(8'h0C, 32'h02);
    req(4'hD);
    pulse(0);
    wait_ack(20, n);
    chk({src, lvl}, 6'h12);
    pulse(0);
    wait_ack(20, n);
    chk(n, 20);
    pulse(2);
    wait_ack(20, n);
    chk(src, 3'h3);
  endtask
  task automatic t_nmi;
    int n;
    pulse(2);
    pulse(3);
    pulse(0);
    wait_ack(20, n);
    chk(n, 20);
    pulse(2);
    wait_ack(20, n);
    chk(src, 3'h0);
  endtask
  task automatic t_ext;
    int n;
    pulse(2);
    wr(8'h10, 32'h01);
    pulse(0);
    @(posedge clk);
    pin <= 4'h1;
    wait_ack(30, n);
    chk({src, lvl}, 6'h21);
    chk(n >= 11 && n <= 20, 1);
  endtask
  task automatic t_block;
    int n;
    pulse(2);
    req(4'h2);
    stby <= 1'b1;
    pulse(0);
    wait_ack(20, n);
    chk(n, 20);
    @(posedge clk);
    stby <= 1'b0;
    pulse(4);
    wait_ack(20, n);
    chk(n, `MIP_ENABLE_WIN_CLKS + 1);
    chk({src, lvl}, 6'h0B);
  endtask
  task automatic stop_test;
    $display("errors=%0d compares=%0d", errors, compares);
    if (errors == 0 && compares > 0) $display("All tests passed");
    else $display("Some tests failed");
    $finish;
  endtask
  initial begin
    repeat (2) @(posedge clk);
    rstn <= 1'b1;
    t_reset;
    t_window;
    t_prio;
    t_nmi;
    t_ext;
    t_block;
    stop_test;
  end
  initial begin
    repeat (5000) @(posedge clk);
    errors++;
    stop_test;
  end
endmodule // tb
`default_nettype wire
